// ### mif_frame_filter.v
/*
  MPLS label stack and IPv4 receive frame filter with AXI4-Lite configuration
  and a verdict FIFO (mif_fifo) in front of the verdict output.
  Assumes a byte stream of received frames, starting at the destination MAC,
  with valid/ready/last handshake, synchronous to clk.
*/
// Added by the designer: the register addresses and the AXI4-Lite slave port.
//
// Contract
// RQ1 - each MPLS entry is four bytes; take 20-bit label and 3-bit class
// RQ2 - match stacks of up to two labels with separate bottom and top criteria
// RQ3 - bottom label ignore: label unused, selects no frame by itself
// RQ4 - bottom label equal-to: pass frames whose bottom label equals the setting
// RQ5 - bottom label compare value held as twenty bits
// RQ6 - bottom class ignore: class unused, selects no frame by itself
// RQ7 - bottom class equal-to: pass frames whose bottom class equals the setting
// RQ8 - bottom class compare value is three bits, against bottom entry class
// RQ9 - top label only meaningful with two labels; ignore or equal-to
// RQ10 - top label is the first entry received after the layer-two header
// RQ11 - top label compare value is twenty bits, compared with top entry label
// RQ12 - top class compares three configured bits with top entry class
// RQ13 - IPv4 selection by source, destination, protocol and DSCP separately
// RQ14 - source and destination address criteria each have a mask
// RQ15 - each address compare value is thirty-two bits
// RQ16 - mask ANDed with configured address; only surviving bits decide
// RQ17 - pass only when every equal-to criterion matches; ignore adds nothing
`timescale 1ns/1ns
`default_nettype none
`include "mif_regs.vh"

////////////////////////////////////////////////////////////////////////////////

module mif_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  // output stage is a register so the consumer sees flop-driven data
  assign inReady = (count_reg != DEPTH[AW:0]);
  assign push = inValid & inReady;
  assign pop = (count_reg != {(AW+1){1'b0}}) & (~outValid | outReady);

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
        outData <= mem[rdPtr_reg];
        outValid <= 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // mif_fifo

////////////////////////////////////////////////////////////////////////////////

module mif_frame_filter #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire rst,
  // received frame byte stream
  input wire inValid,
  output reg inReady,
  input wire [7:0] inData,
  input wire inLast,
  // verdict records
  output wire verdictValid,
  input wire verdictReady,
  output wire [31:0] verdictData,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // configuration
  reg [7:0] ctrl_reg;
  reg [19:0] botLabel_reg; // [RQ5]
  reg [19:0] topLabel_reg; // [RQ11]
  reg [2:0] botTc_reg; // [RQ8]
  reg [2:0] topTc_reg; // [RQ12]
  reg [31:0] srcAddr_reg; // [RQ15]
  reg [31:0] srcMask_reg;
  reg [31:0] dstAddr_reg; // [RQ15]
  reg [31:0] dstMask_reg;
  reg [7:0] proto_reg;
  reg [5:0] dscp_reg;
  reg [31:0] seenCnt_reg;
  reg [31:0] passCnt_reg;

  // frame capture
  reg [5:0] cnt_reg;
  reg [15:0] etype_reg;
  reg [31:0] ent0_reg;
  reg [31:0] ent1_reg;
  reg [3:0] ipVer_reg;
  reg [5:0] ipDscp_reg;
  reg [7:0] ipProto_reg;
  reg [31:0] ipSrc_reg;
  reg [31:0] ipDst_reg;
  reg ipDone_reg;
  reg evalPend_reg;
  reg pushValid_reg;
  reg [31:0] record_reg;

  wire fifoReady;
  wire accept;
  wire isMpls;
  wire [5:0] ipBase;
  wire [5:0] ipRel;
  wire inIp;
  wire depth1;
  wire depth2;
  wire mplsOk;
  wire isIpv4;
  wire [31:0] botEnt;
  wire [7:0] match;
  wire anyEn;
  wire pass;
  wire evalPend_next;
  wire pushValid_next;

  ////////////////////////////////////////////////////////////////////////////
  // frame parsing

  assign accept = inValid & inReady;
  assign isMpls = (etype_reg == `MIF_ETYPE_MPLS_UC) | (etype_reg == `MIF_ETYPE_MPLS_MC);
  // top entry is the one right after the layer-two header [RQ10]
  assign ipBase = ~isMpls ? `MIF_L2_END : (ent0_reg[8] ? `MIF_ENT1_START : `MIF_ENT2_END);
  assign ipRel = cnt_reg - ipBase;
  assign inIp = (cnt_reg >= ipBase) & (etype_reg == `MIF_ETYPE_IPV4 | isMpls);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 6'h00;
      etype_reg <= 16'h0000;
      ent0_reg <= 32'h00000000;
      ent1_reg <= 32'h00000000;
      ipVer_reg <= 4'h0;
      ipDscp_reg <= 6'h00;
      ipProto_reg <= 8'h00;
      ipSrc_reg <= 32'h00000000;
      ipDst_reg <= 32'h00000000;
      ipDone_reg <= 1'b0;
    end else if (evalPend_reg) begin
      // input is stalled here, so the captured fields can be wiped safely
      cnt_reg <= 6'h00;
      etype_reg <= 16'h0000;
      ent0_reg <= 32'h00000000;
      ent1_reg <= 32'h00000000;
      ipDone_reg <= 1'b0;
    end else if (accept) begin
      if (cnt_reg != 6'h3F) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
      if (cnt_reg == `MIF_ETYPE_HI) begin
        etype_reg[15:8] <= inData;
      end
      if (cnt_reg == `MIF_ETYPE_LO) begin
        etype_reg[7:0] <= inData;
      end
      // four-byte stack entries, at most two kept [RQ1] [RQ2]
      if (isMpls && cnt_reg >= `MIF_L2_END && cnt_reg < `MIF_ENT1_START) begin
        ent0_reg <= {ent0_reg[23:0], inData};
      end
      if (isMpls && !ent0_reg[8] && cnt_reg >= `MIF_ENT1_START && cnt_reg < `MIF_ENT2_END) begin
        ent1_reg <= {ent1_reg[23:0], inData};
      end
      if (inIp) begin
        if (ipRel == `MIF_IP_VER) begin
          ipVer_reg <= inData[7:4];
        end
        if (ipRel == `MIF_IP_TOS) begin
          ipDscp_reg <= inData[7:2];
        end
        if (ipRel == `MIF_IP_PROTO) begin
          ipProto_reg <= inData;
        end
        if (ipRel >= `MIF_IP_SRC0 && ipRel < `MIF_IP_DST0) begin
          ipSrc_reg <= {ipSrc_reg[23:0], inData};
        end
        if (ipRel >= `MIF_IP_DST0 && ipRel <= `MIF_IP_LAST) begin
          ipDst_reg <= {ipDst_reg[23:0], inData};
        end
        if (ipRel == `MIF_IP_LAST) begin
          ipDone_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict

  // stacks deeper than two labels are not matched by any MPLS criterion [RQ2]
  assign depth1 = isMpls & ent0_reg[8] & (cnt_reg >= `MIF_ENT1_START);
  assign depth2 = isMpls & ~ent0_reg[8] & ent1_reg[8] & (cnt_reg >= `MIF_ENT2_END);
  assign mplsOk = depth1 | depth2;
  assign botEnt = depth1 ? ent0_reg : ent1_reg;
  assign isIpv4 = ipDone_reg & (ipVer_reg == 4'h4) & ((etype_reg == `MIF_ETYPE_IPV4) | mplsOk);

  assign match[`MIF_EN_BOT_LABEL] = mplsOk & (botEnt[31:12] == botLabel_reg); // [RQ4]
  assign match[`MIF_EN_BOT_TC] = mplsOk & (botEnt[11:9] == botTc_reg); // [RQ7] [RQ8]
  assign match[`MIF_EN_TOP_LABEL] = depth2 & (ent0_reg[31:12] == topLabel_reg); // [RQ9] [RQ11]
  assign match[`MIF_EN_TOP_TC] = depth2 & (ent0_reg[11:9] == topTc_reg); // [RQ12]
  // xor then mask equals comparing the masked values [RQ14] [RQ16]
  assign match[`MIF_EN_SRC] = isIpv4 & (((ipSrc_reg ^ srcAddr_reg) & srcMask_reg) == 32'h00000000);
  assign match[`MIF_EN_DST] = isIpv4 & (((ipDst_reg ^ dstAddr_reg) & dstMask_reg) == 32'h00000000);
  assign match[`MIF_EN_PROTO] = isIpv4 & (ipProto_reg == proto_reg); // [RQ13]
  assign match[`MIF_EN_DSCP] = isIpv4 & (ipDscp_reg == dscp_reg); // [RQ13]

  // ignored criteria neither block nor select [RQ3] [RQ6] [RQ17]
  assign anyEn = |ctrl_reg;
  assign pass = anyEn & (&(match | ~ctrl_reg)); // [RQ17]

  assign evalPend_next = accept & inLast;
  assign pushValid_next = evalPend_reg | (pushValid_reg & ~fifoReady);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inReady <= 1'b0;
      evalPend_reg <= 1'b0;
      pushValid_reg <= 1'b0;
      record_reg <= 32'h00000000;
      seenCnt_reg <= 32'h00000000;
      passCnt_reg <= 32'h00000000;
    end else begin
      // stream stalls from the last byte until the verdict enters the FIFO
      inReady <= ~(evalPend_next | pushValid_next);
      evalPend_reg <= evalPend_next;
      pushValid_reg <= pushValid_next;
      if (evalPend_reg) begin
        record_reg <= {16'h0000, match, 3'h0, depth2, depth1, isIpv4, mplsOk, pass};
        seenCnt_reg <= seenCnt_reg + 32'h00000001;
        if (pass) begin
          passCnt_reg <= passCnt_reg + 32'h00000001;
        end
      end
    end
  end

  mif_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(pushValid_reg),
    .inReady(fifoReady),
    .inData(record_reg),
    .outValid(verdictValid),
    .outReady(verdictReady),
    .outData(verdictData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  function [31:0] strobed;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] st;
    integer i;
    begin
      strobed = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          strobed[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  wire wrTake;
  wire rdTake;
  wire [31:0] tcWord;
  wire [31:0] pdWord;
  reg [31:0] rdMux;
  reg rdHit;
  reg [31:0] wrOld;
  wire [31:0] wrNew;

  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
  assign rdTake = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
  assign tcWord = {25'h0000000, topTc_reg, 1'b0, botTc_reg};
  assign pdWord = {18'h00000, dscp_reg, proto_reg};
  assign wrNew = strobed(wrOld, s_axi_wdata, s_axi_wstrb);

  // old word of the addressed register; unstrobed byte lanes keep it
  always @* begin
    case (s_axi_awaddr)
      `MIF_OFS_CTRL: wrOld = {24'h000000, ctrl_reg};
      `MIF_OFS_BOT_LABEL: wrOld = {12'h000, botLabel_reg};
      `MIF_OFS_TOP_LABEL: wrOld = {12'h000, topLabel_reg};
      `MIF_OFS_TCLASS: wrOld = tcWord;
      `MIF_OFS_PROTO_DSCP: wrOld = pdWord;
      default: wrOld = 32'h00000000;
    endcase
  end

  always @* begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      `MIF_OFS_CTRL: rdMux = {24'h000000, ctrl_reg};
      `MIF_OFS_BOT_LABEL: rdMux = {12'h000, botLabel_reg};
      `MIF_OFS_TOP_LABEL: rdMux = {12'h000, topLabel_reg};
      `MIF_OFS_TCLASS: rdMux = tcWord;
      `MIF_OFS_SRC_ADDR: rdMux = srcAddr_reg;
      `MIF_OFS_SRC_MASK: rdMux = srcMask_reg;
      `MIF_OFS_DST_ADDR: rdMux = dstAddr_reg;
      `MIF_OFS_DST_MASK: rdMux = dstMask_reg;
      `MIF_OFS_PROTO_DSCP: rdMux = pdWord;
      `MIF_OFS_SEEN_CNT: rdMux = seenCnt_reg;
      `MIF_OFS_PASS_CNT: rdMux = passCnt_reg;
      default: begin
        rdMux = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MIF_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MIF_RESP_OKAY;
      ctrl_reg <= `MIF_RST_CTRL;
      botLabel_reg <= `MIF_RST_LABEL;
      topLabel_reg <= `MIF_RST_LABEL;
      botTc_reg <= `MIF_RST_TC;
      topTc_reg <= `MIF_RST_TC;
      srcAddr_reg <= `MIF_RST_ADDR;
      srcMask_reg <= `MIF_RST_MASK;
      dstAddr_reg <= `MIF_RST_ADDR;
      dstMask_reg <= `MIF_RST_MASK;
      proto_reg <= `MIF_RST_PROTO;
      dscp_reg <= `MIF_RST_DSCP;
    end else begin
      // address and data are taken together in one cycle
      s_axi_awready <= wrTake;
      s_axi_wready <= wrTake;
      if (wrTake) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `MIF_RESP_OKAY;
        case (s_axi_awaddr)
          `MIF_OFS_CTRL: ctrl_reg <= wrNew[7:0];
          `MIF_OFS_BOT_LABEL: botLabel_reg <= wrNew[19:0];
          `MIF_OFS_TOP_LABEL: topLabel_reg <= wrNew[19:0];
          `MIF_OFS_TCLASS: begin
            botTc_reg <= wrNew[`MIF_TC_BOT_LSB +: 3];
            topTc_reg <= wrNew[`MIF_TC_TOP_LSB +: 3];
          end
          `MIF_OFS_SRC_ADDR: srcAddr_reg <= strobed(srcAddr_reg, s_axi_wdata, s_axi_wstrb);
          `MIF_OFS_SRC_MASK: srcMask_reg <= strobed(srcMask_reg, s_axi_wdata, s_axi_wstrb);
          `MIF_OFS_DST_ADDR: dstAddr_reg <= strobed(dstAddr_reg, s_axi_wdata, s_axi_wstrb);
          `MIF_OFS_DST_MASK: dstMask_reg <= strobed(dstMask_reg, s_axi_wdata, s_axi_wstrb);
          `MIF_OFS_PROTO_DSCP: begin
            proto_reg <= wrNew[`MIF_PROTO_LSB +: 8];
            dscp_reg <= wrNew[`MIF_DSCP_LSB +: 6];
          end
          `MIF_OFS_SEEN_CNT, `MIF_OFS_PASS_CNT: s_axi_bresp <= `MIF_RESP_OKAY;
          default: s_axi_bresp <= `MIF_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rdTake;
      if (rdTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? `MIF_RESP_OKAY : `MIF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // mif_frame_filter

`default_nettype wire

// ### mif_regs.vh
/*
  Register map, field positions, reset values and frame layout constants
  of the MPLS / IPv4 receive frame filter.
  Assumes inclusion by the filter design file and by the bench; definitions only.
*/
`ifndef MIF_REGS_VH
`define MIF_REGS_VH

// register byte offsets
`define MIF_OFS_CTRL 8'h00
`define MIF_OFS_BOT_LABEL 8'h04
`define MIF_OFS_TOP_LABEL 8'h08
`define MIF_OFS_TCLASS 8'h0C
`define MIF_OFS_SRC_ADDR 8'h10
`define MIF_OFS_SRC_MASK 8'h14
`define MIF_OFS_DST_ADDR 8'h18
`define MIF_OFS_DST_MASK 8'h1C
`define MIF_OFS_PROTO_DSCP 8'h20
`define MIF_OFS_SEEN_CNT 8'h24
`define MIF_OFS_PASS_CNT 8'h28

// equal-to enables in CTRL, one bit per criterion
`define MIF_EN_BOT_LABEL 0
`define MIF_EN_BOT_TC 1
`define MIF_EN_TOP_LABEL 2
`define MIF_EN_TOP_TC 3
`define MIF_EN_SRC 4
`define MIF_EN_DST 5
`define MIF_EN_PROTO 6
`define MIF_EN_DSCP 7
`define MIF_NUM_CRIT 8

// field positions
`define MIF_TC_BOT_LSB 0
`define MIF_TC_TOP_LSB 4
`define MIF_PROTO_LSB 0
`define MIF_DSCP_LSB 8

// reset values
`define MIF_RST_CTRL 8'h00
`define MIF_RST_LABEL 20'h00000
`define MIF_RST_TC 3'h0
`define MIF_RST_ADDR 32'h00000000
`define MIF_RST_MASK 32'hFFFFFFFF
`define MIF_RST_PROTO 8'h00
`define MIF_RST_DSCP 6'h00

// frame layout, byte positions from start of the Ethernet header
`define MIF_ETYPE_HI 6'h0C
`define MIF_ETYPE_LO 6'h0D
`define MIF_L2_END 6'h0E
`define MIF_ENT1_START 6'h12
`define MIF_ENT2_END 6'h16
`define MIF_ETYPE_MPLS_UC 16'h8847
`define MIF_ETYPE_MPLS_MC 16'h8848
`define MIF_ETYPE_IPV4 16'h0800

// IPv4 header byte positions relative to its first byte
`define MIF_IP_VER 6'h00
`define MIF_IP_TOS 6'h01
`define MIF_IP_PROTO 6'h09
`define MIF_IP_SRC0 6'h0C
`define MIF_IP_DST0 6'h10
`define MIF_IP_LAST 6'h13

`define MIF_RESP_OKAY 2'h0
`define MIF_RESP_SLVERR 2'h2

`endif

// ### mif_filter_assertions.sv
/*
  Port timing checker for mif_frame_filter: bus answers, hold rules, verdict records.
  Assumes it is bound onto the filter; single clock, rst active high.
*/
`timescale 1ns/1ns
`default_nettype none
module mif_filter_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic inLast,
  input wire logic verdictValid,
  input wire logic verdictReady,
  input wire logic [31:0] verdictData,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  property p_wrAns;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
      |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
  endproperty
  a_wrAns: assert property (p_wrAns) else $error("write not answered");
  property p_rdAns;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid;
  endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_awPulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_awPulse: assert property (p_awPulse) else $error("awready longer than one cycle");
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
  endproperty
  a_rHold: assert property (p_rHold) else $error("read response dropped");
  property p_badRd;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready && s_axi_araddr >= 8'h2C
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_badRd: assert property (p_badRd) else $error("unmapped read not refused");
  // verdict slot is busy for at least two cycles after a frame ends
  property p_lastStop;
    inValid && inReady && inLast |=> !inReady [*2];
  endproperty
  a_lastStop: assert property (p_lastStop) else $error("byte taken too soon after frame end");
  property p_vHold;
    verdictValid && !verdictReady |=> verdictValid && $stable(verdictData);
  endproperty
  a_vHold: assert property (p_vHold) else $error("verdict record changed while waiting");
  property p_passWhy;
    verdictValid && verdictData[0] |-> verdictData[15:8] != 8'h0
      && (verdictData[1] || verdictData[2]);
  endproperty
  a_passWhy: assert property (p_passWhy) else $error("pass without a matching criterion");
  property p_stack;
    verdictValid |-> verdictData[1] == (verdictData[3] || verdictData[4])
      && !(verdictData[3] && verdictData[4]) && verdictData[31:16] == 16'h0;
  endproperty
  a_stack: assert property (p_stack) else $error("stack depth flags inconsistent");
endmodule // mif_filter_chk
bind mif_frame_filter mif_filter_chk u_mif_filter_chk (.clk, .rst, .inValid, .inReady,
  .inLast, .verdictValid, .verdictReady, .verdictData, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### mif_frame_src.sv
/*
  Far-side model: receive port byte source and verdict taker.
  Assumes one caller of send at a time, entered between clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module mif_frame_src (
  input wire logic clk,
  input wire logic inReady,
  output logic inValid,
  output logic [7:0] inData,
  output logic inLast,
  input wire logic stall,
  output logic verdictReady
);
  initial begin
    inValid = 1'b0;
    inData = 8'h00;
    inLast = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] q[$]);
    @(posedge clk);
    for (int i = 0; i < q.size(); i++) begin
      inValid <= 1'b1;
      inData <= q[i];
      inLast <= i == q.size() - 1;
      do @(posedge clk); while (!inReady);
    end
    inValid <= 1'b0;
    inLast <= 1'b0;
    // idle lane shows the inverse so a stale byte never looks valid
    inData <= ~inData;
  endtask
  always @(posedge clk) verdictReady <= !stall;
endmodule // mif_frame_src
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench for mif_frame_filter: bus tasks, frame scenarios, verdict queue.
  Assumes mif_frame_src as the port side and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mif_regs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic inValid, inReady, inLast, verdictValid, verdictReady, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rndStall;
  logic stall = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] inData, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] verdictData, s_axi_rdata, s_axi_wdata = 32'h0, seed = 32'h1303C;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] busQ[$];
  logic [4:0] vQ[$];
  logic [7:0] fq[$];
  logic [31:0] cfg[9];
  logic [19:0] fLab[3];
  logic [2:0] fTc[3];
  logic [31:0] fSrc, fDst;
  logic [7:0] fProto;
  logic [5:0] fDscp;
  int nLab, nFail, checkCount, nSeen, nPass;
  always #50 clk = ~clk;
  mif_frame_filter u_mif_frame_filter (.clk, .rst, .inValid, .inReady, .inData, .inLast,
    .verdictValid, .verdictReady, .verdictData, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mif_frame_src u_mif_frame_src (.clk, .inReady, .inValid, .inData, .inLast, .stall,
    .verdictReady);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_bus(input logic [33:0] e, input logic [33:0] got);
    checkCount++;
    if (got !== e) begin
      nFail++;
      $display("wrong value at %0t: bus %h exp %h", $time, got, e);
    end
  endtask
  task automatic chk_vd(input logic [4:0] e, input logic [31:0] got);
    checkCount++;
    if (got[31:16] !== 16'h0 || got[4:0] !== e) begin
      nFail++;
      $display("wrong value at %0t: verdict %h exp %h", $time, got, e);
    end
  endtask
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk_bus(busQ.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) chk_bus(busQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (verdictValid && verdictReady) chk_vd(vQ.pop_front(), verdictData);
    if (rndStall) stall <= 1'(xs());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    busQ.push_back({r, 32'h0});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    busQ.push_back({r, d});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  function automatic logic [4:0] model();
    logic [7:0] m;
    logic stk;
    logic ip;
    int bi;
    bi = nLab > 0 ? nLab - 1 : 0;
    stk = nLab == 1 || nLab == 2;
    ip = nLab < 3;
    m[0] = stk && fLab[bi] == cfg[1][19:0];
    m[1] = stk && fTc[bi] == cfg[3][2:0];
    m[2] = nLab == 2 && fLab[0] == cfg[2][19:0];
    m[3] = nLab == 2 && fTc[0] == cfg[3][6:4];
    m[4] = ip && ((fSrc ^ cfg[4]) & cfg[5]) == 32'h0;
    m[5] = ip && ((fDst ^ cfg[6]) & cfg[7]) == 32'h0;
    m[6] = ip && fProto == cfg[8][7:0];
    m[7] = ip && fDscp == cfg[8][13:8];
    return {nLab == 2, nLab == 1, ip, stk, cfg[0][7:0] != 8'h0 && (m | ~cfg[0][7:0]) == 8'hFF};
  endfunction
  task automatic put(input logic [31:0] w);
    for (int k = 3; k >= 0; k--) fq.push_back(w[k*8+:8]);
  endtask
  task automatic run(input logic [7:0] en, input int n, input int flip);
    int bi;
    cfg[0] = {24'h0, en};
    cfg[1] = xs() & 32'hFFFFF;
    cfg[2] = xs() & 32'hFFFFF;
    cfg[3] = xs() & 32'h77;
    for (int i = 4; i < 8; i++) cfg[i] = xs() | (i % 2 ? 32'h80000000 : 32'h0);
    cfg[8] = xs() & 32'h3FFF;
    for (int i = 0; i < 9; i++) wr(8'(i * 4), cfg[i], 2'h0);
    nLab = n;
    bi = n > 0 ? n - 1 : 0;
    for (int i = 0; i < 3; i++) begin
      fLab[i] = 20'(xs());
      fTc[i] = 3'(xs());
    end
    fLab[0] = cfg[2][19:0];
    fTc[0] = cfg[3][6:4];
    fLab[bi] = cfg[1][19:0];
    fTc[bi] = cfg[3][2:0];
    fSrc = cfg[4] ^ (xs() & ~cfg[5]);
    fDst = cfg[6] ^ (xs() & ~cfg[7]);
    fProto = cfg[8][7:0];
    fDscp = cfg[8][13:8];
    case (flip)
      0: fLab[bi] ^= 20'h1;
      1: fTc[bi] ^= 3'h1;
      2: fLab[0] ^= 20'h1;
      3: fTc[0] ^= 3'h1;
      4: fSrc[31] ^= 1'b1;
      5: fDst[31] ^= 1'b1;
      6: fProto ^= 8'h1;
      7: fDscp ^= 6'h1;
      default: ;
    endcase
    vQ.push_back(model());
    nSeen++;
    if (vQ[$][0]) nPass++;
    fq = {};
    repeat (12) fq.push_back(8'(xs()));
    put({nLab ? 16'h8847 : 16'h0800, 16'h4500});
    fq.pop_back();
    fq.pop_back();
    for (int i = 0; i < nLab; i++) put({fLab[i], fTc[i], i == nLab - 1, 8'h40});
    put({8'h45, fDscp, 2'b00, 16'h0014});
    put(32'h0);
    put({8'h40, fProto, 16'h0});
    put(fSrc);
    put(fDst);
    u_mif_frame_src.send(fq);
    $display("test done ctrl %h labels %0d flip %0d", en, n, flip);
  endtask
  initial begin
    rndStall = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`MIF_OFS_CTRL, 32'h0, 2'h0);
    rd(`MIF_OFS_SRC_MASK, 32'hFFFFFFFF, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(`MIF_OFS_SEEN_CNT, 32'h5, 2'h0);
    wr(`MIF_OFS_BOT_LABEL, 32'hFFFFFFFF, 2'h0);
    rd(`MIF_OFS_BOT_LABEL, 32'h000FFFFF, 2'h0);
    wr(`MIF_OFS_TCLASS, 32'hFFFFFFFF, 2'h0);
    rd(`MIF_OFS_TCLASS, 32'h00000077, 2'h0);
    rndStall = 1'b1;
    for (int i = 0; i < 8; i++) begin
      run(8'h1 << i, (i == 2 || i == 3) ? 2 : 1 + i % 2, 8);
      run(8'h1 << i, (i == 2 || i == 3) ? 2 : 1 + i % 2, i);
    end
    run(8'h00, 2, 8);
    run(8'hFF, 2, 8);
    run(8'hFF, 2, 5);
    run(8'h04, 1, 8);
    run(8'h01, 3, 8);
    run(8'h30, 0, 8);
    rndStall = 1'b0;
    stall <= 1'b1;
    repeat (9) run(8'hC0, 0, 8);
    fork
      run(8'hC0, 0, 8);
      begin
        repeat (600) @(posedge clk);
        stall <= 1'b0;
      end
    join
    rd(`MIF_OFS_SEEN_CNT, 32'(nSeen), 2'h0);
    rd(`MIF_OFS_PASS_CNT, 32'(nPass), 2'h0);
    wait (vQ.size() == 0);
    repeat (5) @(posedge clk);
    printVerdict();
  end
  initial begin
    #6000000;
    nFail++;
    printVerdict();
  end
endmodule // tb_top
`default_nettype wire
